// ==== prsl_consts.vh ====
// Constants for the processor reset and strap decoding block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef PRSL_CONSTS_VH
`define PRSL_CONSTS_VH

// Minimum reset hold, in double-rate clock cycles
`define PRSL_RESET_MIN_CYCLES 41
// Width of the reset hold counter
`define PRSL_HOLD_CNT_W 8
// Default self-test length in cycles (arbitrary plain value)
`define PRSL_SELFTEST_CYCLES 64
// Default checksum length in cycles, one per memory word
`define PRSL_CHECKSUM_WORDS 8

// Strap action codes
`define PRSL_ACT_SELFTEST 3'h0
`define PRSL_ACT_SKIP 3'h1
`define PRSL_ACT_RESERVED 3'h2
`define PRSL_ACT_FLOAT 3'h3
`define PRSL_ACT_UNDEF 3'h4

// Sequencer states
`define PRSL_ST_RESET 3'h0
`define PRSL_ST_SELFTEST 3'h1
`define PRSL_ST_CHECKSUM 3'h2
`define PRSL_ST_RUN 3'h3
`define PRSL_ST_FAIL 3'h4
`define PRSL_ST_FLOAT 3'h5

// Status bits of the sticky event register
`define PRSL_EV_SHORT 0
`define PRSL_EV_FAIL 1
`define PRSL_EV_FLOAT 2
`define PRSL_EV_RESERVED 3
`define PRSL_EV_W 4

// Register indices on the plain register port
`define PRSL_REG_STATUS 2'h0
`define PRSL_REG_MASK 2'h1
`define PRSL_REG_STRAPS 2'h2
`define PRSL_REG_HOLDCNT 2'h3

`endif

// ==== prsl_reset_strap.v ====
// Reset entry, strap capture and initialization sequencing for the processor core.
// Assumes one clock (the double-rate clock), inputs synchronous to it, and a
// plain register port with read data one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
`include "prsl_consts.vh"

module prsl_reset_strap #(
	parameter SELFTEST_CYCLES = `PRSL_SELFTEST_CYCLES,
	parameter CHECKSUM_WORDS = `PRSL_CHECKSUM_WORDS
) (
	input wire sys_clk, // Double-rate clock, 125 MHz
	input wire rst, // Reset input, active high, asynchronous
	input wire interrupt_line_0_strap, // Strap, interrupt line 0 level
	input wire interrupt_line_1_strap, // Strap, interrupt line 1 level
	input wire interrupt_line_3_strap, // Strap, interrupt line 3 level
	input wire bus_lock_strap, // Strap, bus lock level
	input wire hold_request, // Ordinary input, ignored in reset
	input wire selftest_pass, // Self-test result, sampled at its end
	input wire checksum_pass, // Zero checksum result, sampled at its end
	input wire first_bus_cycle, // Pulse, first bus transaction starts
	input wire [1:0] reg_addr, // Register index
	input wire [7:0] reg_wdata, // Register write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [7:0] reg_rdata, // Read data, cycle after strobe
	output reg irq, // Level interrupt, unmasked status set
	output reg transfer_direction, // Kept driven in reset
	output reg data_enable_strobe, // Kept driven in reset, inactive
	output reg address_strobe, // Kept driven in reset, inactive
	output reg transfer_direction_oe, // Enable, high while driven
	output reg data_enable_strobe_oe, // Enable, high while driven
	output reg address_strobe_oe, // Enable, high while driven
	output reg burst_final_cycle, // Active high burst last / fail flag
	output reg burst_final_cycle_oe, // Enable for burst final pin
	output reg [1:0] byte_lane_selects, // Active high lane selects
	output reg byte_lane_selects_oe, // Enable for lane selects
	output reg hold_grant, // Hold grant, driven except in float mode
	output reg hold_grant_oe, // Enable for hold grant
	output reg all_outputs_float_mode, // High while floating mode active
	output reg core_run // High once initialization completes
);

////////////////////////////////////////////////////////////////////////////////
// Strap decode, shared by capture and status

	// Map strap levels to an action code
	function [2:0] prsl_decode;
		input i0;
		input i1;
		input i3;
		input lk;
		begin
			if (!lk)
				prsl_decode = `PRSL_ACT_FLOAT;
			else if (!i0 && i1)
				prsl_decode = `PRSL_ACT_RESERVED;
			else if (i0 && i3)
				prsl_decode = `PRSL_ACT_SELFTEST;
			else if (!i0 && !i1 && i3)
				prsl_decode = `PRSL_ACT_SKIP;
			else
				prsl_decode = `PRSL_ACT_UNDEF;
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Reset hold counter and strap capture

	reg [`PRSL_HOLD_CNT_W-1:0] hold_cnt_q; // Cycles reset was seen held
	reg [`PRSL_HOLD_CNT_W-1:0] last_hold_q; // Length of last reset pulse
	reg [3:0] straps_q; // Latched straps {lock,i3,i1,i0}
	reg in_reset_q; // Reset seen on last edge
	reg release_q; // One-cycle pulse after release
	reg [2:0] action_q; // Decoded strap action
	reg rst_prev_q; // Reset level seen on the last edge

	// Release detect: high through reset, then a one-cycle pulse after it
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			in_reset_q <= 1'b1;
			release_q <= 1'b0;
		end
		else
		begin
			in_reset_q <= 1'b0;
			release_q <= in_reset_q;
		end
	end

	// Straps are sampled on every edge while reset holds; the final sample
	// before release is kept
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			straps_q <= {bus_lock_strap, interrupt_line_3_strap,
				interrupt_line_1_strap, interrupt_line_0_strap};
			// First edge of a pulse loads one; an unknown power-up level
			// takes this branch too, so the power-on pulse counts cleanly
			if (rst_prev_q)
			begin
				if (hold_cnt_q != {`PRSL_HOLD_CNT_W{1'b1}})
					hold_cnt_q <= hold_cnt_q + 1'b1;
			end
			else
				hold_cnt_q <= {{(`PRSL_HOLD_CNT_W-1){1'b0}}, 1'b1};
		end
		else
			hold_cnt_q <= {`PRSL_HOLD_CNT_W{1'b0}};
		rst_prev_q <= rst; // Plain flop, no reset, marks pulse start
	end

	// Record pulse length and decode at the release edge
	always @(posedge sys_clk)
	begin
		if (in_reset_q && !rst)
		begin
			last_hold_q <= hold_cnt_q;
			action_q <= prsl_decode(straps_q[0], straps_q[1], straps_q[2], straps_q[3]);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Initialization sequencer

	reg [2:0] state_q; // Sequencer state
	reg [15:0] step_q; // Cycles within a phase
	reg fail_q; // Failure indication
	reg first_seen_q; // First bus transaction has begun

	// Reset returns to the reset state; every release reruns init
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= `PRSL_ST_RESET;
			step_q <= 16'h0000;
			fail_q <= 1'b0;
			first_seen_q <= 1'b0;
		end
		else
		begin
			if (first_bus_cycle)
				first_seen_q <= 1'b1;
			case (state_q)
				`PRSL_ST_RESET:
				begin
					// Wait for the decode pulse one edge after release
					if (release_q)
					begin
						step_q <= 16'h0000;
						case (action_q)
							`PRSL_ACT_FLOAT: state_q <= `PRSL_ST_FLOAT;
							`PRSL_ACT_SELFTEST:
							begin
								state_q <= `PRSL_ST_SELFTEST;
								fail_q <= 1'b1;
							end
							`PRSL_ACT_SKIP: state_q <= `PRSL_ST_CHECKSUM;
							default:
							begin
								// Forbidden straps: report failure, do not run
								state_q <= `PRSL_ST_FAIL;
								fail_q <= 1'b1;
							end
						endcase
					end
				end
				`PRSL_ST_SELFTEST:
				begin
					step_q <= step_q + 16'h0001;
					if (step_q == SELFTEST_CYCLES - 1)
					begin
						step_q <= 16'h0000;
						if (selftest_pass)
						begin
							fail_q <= 1'b0;
							state_q <= `PRSL_ST_CHECKSUM;
						end
						else
							state_q <= `PRSL_ST_FAIL;
					end
				end
				`PRSL_ST_CHECKSUM:
				begin
					step_q <= step_q + 16'h0001;
					if (step_q == CHECKSUM_WORDS - 1)
					begin
						if (checksum_pass)
							state_q <= `PRSL_ST_RUN;
						else
						begin
							fail_q <= 1'b1;
							state_q <= `PRSL_ST_FAIL;
						end
					end
				end
				`PRSL_ST_FAIL: state_q <= `PRSL_ST_FAIL; // Held until reset
				`PRSL_ST_FLOAT: state_q <= `PRSL_ST_FLOAT; // Held until reset
				`PRSL_ST_RUN: state_q <= `PRSL_ST_RUN;
				default: state_q <= `PRSL_ST_RESET;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Pin drive

	// All pins registered; reset values give the in-reset pin picture
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			transfer_direction <= 1'b0;
			data_enable_strobe <= 1'b0;
			address_strobe <= 1'b0;
			transfer_direction_oe <= 1'b1;
			data_enable_strobe_oe <= 1'b1;
			address_strobe_oe <= 1'b1;
			burst_final_cycle <= 1'b0;
			burst_final_cycle_oe <= 1'b0;
			byte_lane_selects <= 2'h0;
			byte_lane_selects_oe <= 1'b0;
			hold_grant <= 1'b0;
			hold_grant_oe <= 1'b1;
			all_outputs_float_mode <= 1'b0;
			core_run <= 1'b0;
		end
		else if (state_q == `PRSL_ST_FLOAT)
		begin
			// Every output released, enables all low
			transfer_direction_oe <= 1'b0;
			data_enable_strobe_oe <= 1'b0;
			address_strobe_oe <= 1'b0;
			burst_final_cycle_oe <= 1'b0;
			byte_lane_selects_oe <= 1'b0;
			hold_grant_oe <= 1'b0;
			all_outputs_float_mode <= 1'b1;
			core_run <= 1'b0;
		end
		else if (state_q != `PRSL_ST_RESET)
		begin
			// Failure code visible until the first bus transaction
			burst_final_cycle_oe <= !first_seen_q;
			byte_lane_selects_oe <= !first_seen_q;
			burst_final_cycle <= fail_q && !first_seen_q;
			byte_lane_selects <= 2'h0;
			hold_grant <= 1'b0; // Arbitration lives elsewhere; hold ignored here
			hold_grant_oe <= 1'b1;
			core_run <= (state_q == `PRSL_ST_RUN);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Event status, mask, interrupt and register port

	reg [`PRSL_EV_W-1:0] status_q; // Sticky events, cleared by read
	reg [`PRSL_EV_W-1:0] mask_q; // One enables an event
	reg [`PRSL_EV_W-1:0] ev_set; // Events this cycle

	// Event pulses; short pulse judged against the minimum hold
	always @*
	begin
		ev_set = {`PRSL_EV_W{1'b0}};
		ev_set[`PRSL_EV_SHORT] = (in_reset_q && !rst)
			&& (hold_cnt_q < `PRSL_RESET_MIN_CYCLES);
		ev_set[`PRSL_EV_FAIL] = (state_q != `PRSL_ST_FAIL) && (state_q != `PRSL_ST_RESET)
			&& !(state_q == `PRSL_ST_SELFTEST && selftest_pass)
			&& !(state_q == `PRSL_ST_CHECKSUM && checksum_pass)
			&& (step_q == ((state_q == `PRSL_ST_SELFTEST) ? SELFTEST_CYCLES - 1
				: CHECKSUM_WORDS - 1))
			&& (state_q == `PRSL_ST_SELFTEST || state_q == `PRSL_ST_CHECKSUM);
		ev_set[`PRSL_EV_FLOAT] = release_q && (action_q == `PRSL_ACT_FLOAT);
		ev_set[`PRSL_EV_RESERVED] = release_q && (action_q == `PRSL_ACT_RESERVED
			|| action_q == `PRSL_ACT_UNDEF);
	end

	// Register port: a status read clears, but a new event wins over it
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			status_q <= {`PRSL_EV_W{1'b0}};
			mask_q <= {`PRSL_EV_W{1'b0}};
			reg_rdata <= 8'h00;
			irq <= 1'b0;
		end
		else
		begin
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				case (reg_addr)
					`PRSL_REG_STATUS: reg_rdata <= {4'h0, status_q};
					`PRSL_REG_MASK: reg_rdata <= {4'h0, mask_q};
					`PRSL_REG_STRAPS: reg_rdata <= {1'b0, action_q, straps_q};
					`PRSL_REG_HOLDCNT: reg_rdata <= last_hold_q;
					default: reg_rdata <= 8'h00;
				endcase
			end
			if (reg_rd && reg_addr == `PRSL_REG_STATUS)
				status_q <= ev_set;
			else
				status_q <= status_q | ev_set;
			if (reg_wr && reg_addr == `PRSL_REG_MASK)
				mask_q <= reg_wdata[`PRSL_EV_W-1:0];
			irq <= |(((reg_rd && reg_addr == `PRSL_REG_STATUS) ? ev_set
				: (status_q | ev_set)) & ((reg_wr && reg_addr == `PRSL_REG_MASK)
				? reg_wdata[`PRSL_EV_W-1:0] : mask_q));
		end
	end

endmodule

`default_nettype wire

// ==== prsl_props.sv ====
// Checker for reset entry and strap decoding, watching the block's pins.
// Assumes it is bound onto prsl_reset_strap.
`timescale 1ns/1ns
`default_nettype none
module prsl_props #(
	parameter SELFTEST_CYCLES = 64,
	parameter CHECKSUM_WORDS = 8
) (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic interrupt_line_0_strap, // Strap
	input wire logic interrupt_line_3_strap, // Strap
	input wire logic bus_lock_strap, // Strap
	input wire logic first_bus_cycle, // First bus cycle
	input wire logic transfer_direction, // Pin
	input wire logic transfer_direction_oe, // Enable
	input wire logic address_strobe_oe, // Enable
	input wire logic burst_final_cycle, // Fail flag
	input wire logic burst_final_cycle_oe, // Enable
	input wire logic [1:0] byte_lane_selects, // Lanes
	input wire logic byte_lane_selects_oe, // Enable
	input wire logic hold_grant, // Grant
	input wire logic hold_grant_oe, // Enable
	input wire logic all_outputs_float_mode, // Float mode
	input wire logic core_run // Running
);
	// One clock; reset-time properties must not be disabled by reset
	default clocking cb @(posedge sys_clk); endclocking
	AST_RST_FLOAT: assert property (rst |-> transfer_direction_oe && address_strobe_oe
		&& !burst_final_cycle_oe && !byte_lane_selects_oe) else $error("reset pin enables wrong");
	AST_RST_IDLE: assert property (rst |-> !transfer_direction && !core_run
		&& !all_outputs_float_mode) else $error("reset outputs not inactive");
	AST_HOLD_LOW: assert property (rst |-> hold_grant_oe && !hold_grant)
		else $error("hold grant not driven low");
	AST_FLOAT_IN: assert property (disable iff (rst) $fell(rst) && !$past(bus_lock_strap)
		|-> ##[1:3] all_outputs_float_mode) else $error("float mode not entered");
	AST_FLOAT_STAY: assert property (disable iff (rst) all_outputs_float_mode
		|=> all_outputs_float_mode) else $error("float mode left");
	AST_FLOAT_OFF: assert property (disable iff (rst) all_outputs_float_mode
		|-> !(transfer_direction_oe || address_strobe_oe || burst_final_cycle_oe
		|| byte_lane_selects_oe)) else $error("pin driven in float mode");
	AST_TEST_FAIL: assert property (disable iff (rst) $fell(rst) && $past(bus_lock_strap)
		&& $past(interrupt_line_0_strap) && $past(interrupt_line_3_strap)
		|-> ##[1:4] burst_final_cycle && burst_final_cycle_oe) else $error("no fail in self-test");
	AST_FAIL_CODE: assert property (disable iff (rst) burst_final_cycle
		&& burst_final_cycle_oe |-> byte_lane_selects == 2'h0) else $error("lanes set in fail code");
	AST_FAIL_END: assert property (disable iff (rst) first_bus_cycle && core_run
		|-> ##[1:2] !burst_final_cycle_oe) else $error("fail code kept after bus start");
	AST_RUN_OK: assert property (disable iff (rst) core_run |-> !burst_final_cycle)
		else $error("fail flag while running");
endmodule
bind prsl_reset_strap prsl_props #(.SELFTEST_CYCLES(SELFTEST_CYCLES),
	.CHECKSUM_WORDS(CHECKSUM_WORDS)) u_props (.sys_clk(sys_clk), .rst(rst),
	.interrupt_line_0_strap(interrupt_line_0_strap), .bus_lock_strap(bus_lock_strap),
	.interrupt_line_3_strap(interrupt_line_3_strap), .first_bus_cycle(first_bus_cycle),
	.transfer_direction(transfer_direction), .transfer_direction_oe(transfer_direction_oe),
	.address_strobe_oe(address_strobe_oe), .burst_final_cycle(burst_final_cycle),
	.burst_final_cycle_oe(burst_final_cycle_oe), .byte_lane_selects(byte_lane_selects),
	.byte_lane_selects_oe(byte_lane_selects_oe), .hold_grant(hold_grant),
	.hold_grant_oe(hold_grant_oe), .all_outputs_float_mode(all_outputs_float_mode),
	.core_run(core_run));
`default_nettype wire

// ==== prsl_rst_src.sv ====
// Model of the system reset generator and strap pull logic.
// Assumes go is a one-cycle request from the bench, on the same clock.
`timescale 1ns/1ns
`default_nettype none
module prsl_rst_src (
	input wire logic sys_clk, // Clock
	input wire logic go, // Start one reset pulse
	input wire logic [7:0] len, // Pulse length in cycles
	input wire logic [3:0] strap, // Levels {lock,i3,i1,i0} in reset
	output logic rst, // Reset to the device
	output logic [3:0] pins // Strap pins {lock,i3,i1,i0}
);
	logic [7:0] cnt_q = 8'h0C; // Power-on hold of 12 cycles
	// Low at time zero, then high, so the design sees a real reset edge
	initial
	begin
		rst = 1'b0;
		#1 rst = 1'b1;
	end
	initial pins = 4'hD;
	// Edges move only just after a clock rise; out of reset the pins
	// flip every cycle, since they are ordinary inputs then
	always @(posedge sys_clk)
	begin
		if (go)
		begin
			rst <= 1'b1;
			cnt_q <= len;
			pins <= strap;
		end
		else if (cnt_q != 8'h00)
		begin
			cnt_q <= cnt_q - 8'h01;
			rst <= (cnt_q != 8'h01);
		end
		else
			pins <= ~pins;
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench: reset pulses, strap decoding, register port.
// Assumes the reset model drives rst and the strap pins.
`timescale 1ns/1ns
`default_nettype none
`include "prsl_consts.vh"
module tb_top;
	logic sys_clk = 1'b0;
	logic rst, go = 1'b0, sp = 1'b1, cp = 1'b1, fb = 1'b0, hr = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic [7:0] len = 8'h29, wd = 8'h00, rdata, v;
	logic [3:0] strap = 4'hD, pins;
	logic [1:0] ad = 2'h0, bl;
	logic irq, td, de, ast, td_oe, de_oe, as_oe, bf, bf_oe, bl_oe, hg, hg_oe, flt, run;
	int n_errors = 0, checks = 0, cyc = 0;
	always #4 sys_clk = ~sys_clk;
	prsl_rst_src u_src (.sys_clk(sys_clk), .go(go), .len(len), .strap(strap), .rst(rst),
		.pins(pins));
	prsl_reset_strap #(.SELFTEST_CYCLES(4), .CHECKSUM_WORDS(2)) DUT (.sys_clk(sys_clk),
		.rst(rst), .interrupt_line_0_strap(pins[0]), .interrupt_line_1_strap(pins[1]),
		.interrupt_line_3_strap(pins[2]), .bus_lock_strap(pins[3]), .hold_request(hr),
		.selftest_pass(sp), .checksum_pass(cp), .first_bus_cycle(fb), .reg_addr(ad),
		.reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .irq(irq),
		.transfer_direction(td), .data_enable_strobe(de), .address_strobe(ast),
		.transfer_direction_oe(td_oe), .data_enable_strobe_oe(de_oe),
		.address_strobe_oe(as_oe), .burst_final_cycle(bf), .burst_final_cycle_oe(bf_oe),
		.byte_lane_selects(bl), .byte_lane_selects_oe(bl_oe), .hold_grant(hg),
		.hold_grant_oe(hg_oe), .all_outputs_float_mode(flt), .core_run(run));
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask
	// One-cycle strobes; read data taken in the cycle after the strobe
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		ad <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge sys_clk);
		ad <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	// Bounded wait for the end of initialization, then its outcome
	task automatic wait_run(input logic e);
		for (int i = 0; i < 40 && run !== 1'b1; i++)
			@(posedge sys_clk);
		#1 chk({7'h0, run}, {7'h0, e}, "run state");
	endtask
	// Pins three cycles after release: {float, direction oe, fail oe, fail}
	task automatic boot(input logic [7:0] n, input logic [3:0] s, input logic p, c,
		input logic [3:0] e3, input logic [7:0] es, st, care);
		@(posedge sys_clk);
		go <= 1'b1;
		len <= n;
		strap <= s;
		sp <= p;
		cp <= c;
		@(posedge sys_clk);
		go <= 1'b0;
		@(negedge rst);
		repeat (3) @(posedge sys_clk);
		#1 chk({4'h0, flt, td_oe, bf_oe, bf}, {4'h0, e3}, "pins after release");
		wait_run(st == 8'h00);
		if (st[2] === 1'b0)
			chk({7'h0, bf}, {7'h0, st != 8'h00}, "fail flag");
		rd(`PRSL_REG_STRAPS);
		chk(v, es, "latched straps");
		wr(`PRSL_REG_MASK, 8'h0F);
		@(posedge sys_clk);
		#1 chk({7'h0, irq}, {7'h0, st != 8'h00}, "irq unmasked");
		rd(`PRSL_REG_MASK);
		chk(v, 8'h0F, "mask");
		rd(`PRSL_REG_STATUS);
		chk(v & care, st, "status");
		wr(`PRSL_REG_MASK, 8'h00);
		@(posedge sys_clk);
		#1 chk({7'h0, irq}, 8'h00, "irq masked");
		rd(`PRSL_REG_HOLDCNT);
		chk(v, n, "hold count");
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 4000)
		begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			give_verdict();
		end
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		#1 chk({td_oe, de_oe, as_oe, bf_oe, bl_oe, hg_oe, hg, run}, 8'hE4, "reset pins");
		chk({3'h0, td, de, ast, irq, flt}, 8'h00, "reset levels");
		@(negedge rst);
		repeat (3) @(posedge sys_clk);
		#1 chk({4'h0, bf, bf_oe, bl}, 8'h0C, "fail code");
		wait_run(1'b1);
		rd(`PRSL_REG_STATUS);
		chk(v, 8'h01, "short reset flagged");
		rd(`PRSL_REG_STATUS);
		chk(v, 8'h00, "status cleared by read");
		rd(`PRSL_REG_HOLDCNT);
		chk(v, 8'h0C, "power-on hold");
		@(posedge sys_clk);
		fb <= 1'b1;
		@(posedge sys_clk);
		fb <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h0, bf_oe}, 8'h00, "fail code ends");
		boot(8'h29, 4'hD, 1'b1, 1'b1, 4'h7, 8'h0D, 8'h00, 8'hFF);
		boot(8'h28, 4'hD, 1'b0, 1'b1, 4'h7, 8'h0D, 8'h03, 8'hFF);
		boot(8'h29, 4'hC, 1'b1, 1'b0, 4'h6, 8'h1C, 8'h02, 8'hFF);
		boot(8'h29, 4'hE, 1'b1, 1'b1, 4'h7, 8'h2E, 8'h08, 8'hFF);
		boot(8'h29, 4'h9, 1'b1, 1'b1, 4'h7, 8'h49, 8'h08, 8'hFF);
		boot(8'h29, 4'h5, 1'b1, 1'b1, 4'h8, 8'h35, 8'h04, 8'hFF);
		boot(8'h29, 4'hD, 1'b1, 1'b1, 4'h7, 8'h0D, 8'h00, 8'hFF);
		give_verdict();
	end
endmodule
`default_nettype wire
